// >>> rtl/pis_top.sv
// Purpose: peripheral interrupt request flags, enables, vectoring and time bases
// Assumes: event inputs are one-cycle pulses synchronous to pclk; core acks a vector with a pulse
// Notes: registers on apb; vector number equals the flag bit index
// Summary of operation
// - write-done event sets memory write-done flag
// - write-done vectors via global, own, group enables
// - write-done service clears group flag and global
// - conversion flag vectors, service clears it, global
// - three groups: timers, write-done plus low-voltage
// - enabled member event sets its group flag
// - group service leaves member flags set
// - sync serial flag on byte, match, time-out
// - sync serial vectors when enabled, service clears
// - second serial flag per byte, service clears
// - async channel condition gives low request pulse
// - async service clears channel flag, not status
// - over-voltage flag, vector, service clears it
// - time-base overflow flags vector and clear
// - two-bit field selects prescaler source clock
// - no vector while call stack is full
// - time base on bit, period 2^8..2^15
// - any hardware-set flag rising wakes, regardless of enables
// - reti restores global enable, plain return not
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "pis_consts.svh"
module pis_top #(
  parameter int ADDR_W = 8,
  parameter int NUM_TM = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ev_mem_write_done,
  input wire logic ev_conv_done,
  input wire logic ev_sync_byte,
  input wire logic ev_sync_addr_match,
  input wire logic ev_sync_timeout,
  input wire logic ev_second_serial,
  input wire logic [5:0] async0_cond,
  input wire logic [5:0] async1_cond,
  input wire logic ev_overvolt,
  input wire logic ev_low_volt,
  input wire logic [NUM_TM-1:0] tm_req,
  input wire logic sub_tick,
  input wire logic stack_full,
  input wire logic core_ack,
  input wire logic core_reti,
  output logic vec_req,
  output logic [3:0] vec_id,
  output logic wake
);

  pis_pkg::pis_state_t st; // registered state
  pis_pkg::pis_state_t nxt_st; // next state
  logic psc_tick; // prescaler enable
  logic [1:0] tb_ovf; // time base overflows
  logic [1:0] async_any; // any async condition per channel
  logic [`PIS_FLAG_W-1:0] hw_set; // hardware set events
  logic [`PIS_FLAG_W-1:0] sw_set; // software set
  logic [`PIS_FLAG_W-1:0] clr; // clears
  logic [`PIS_NUM_VEC-1:0] pend; // enabled pending vectors
  logic [3:0] pri_id; // winning vector
  logic acc; // apb access phase
  logic done; // apb completing edge
  logic wr; // write takes effect
  logic [31:0] wmask; // byte lane mask
  logic [31:0] rdata; // read mux
  logic rerr; // unmapped address
  logic [7:0] addr; // low address byte

  // prescaler source
  pis_prescaler u_psc (
    .pclk(pclk),
    .presetn(presetn),
    .sel(st.psc_sel),
    .sub_tick(sub_tick),
    .psc_tick(psc_tick)
  );

  // two time bases
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_tb
      pis_timebase u_tb (
        .pclk(pclk),
        .presetn(presetn),
        .tb_on((gi == 0) ? st.tb_ctrl0[`PIS_TB_ON] : st.tb_ctrl1[`PIS_TB_ON]),
        .period((gi == 0) ? st.tb_ctrl0[`PIS_TB_PER_W-1:0] : st.tb_ctrl1[`PIS_TB_PER_W-1:0]),
        .psc_tick(psc_tick),
        .tb_ovf(tb_ovf[gi])
      );
    end
  endgenerate

  // async channel condition gathering
  assign async_any[0] = |async0_cond;
  assign async_any[1] = |async1_cond;

  // apb phase decode and byte lanes
  always_comb
  begin
    addr = 8'(paddr);
    acc = psel & penable;
    done = acc & st.pready;
    wr = done & pwrite;
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // read mux with unmapped decode
  always_comb
  begin
    rdata = 32'h00000000;
    rerr = 1'b0;
    case (addr)
      `PIS_OFF_CTRL: rdata = {31'h00000000, st.gie};
      `PIS_OFF_ENABLE: rdata = {12'h000, st.enables};
      `PIS_OFF_FLAG: rdata = {12'h000, st.flags};
      `PIS_OFF_FLAG_SET: rdata = {12'h000, st.flags};
      `PIS_OFF_PSC: rdata = {30'h00000000, st.psc_sel};
      `PIS_OFF_TB0: rdata = {24'h000000, st.tb_ctrl0};
      `PIS_OFF_TB1: rdata = {24'h000000, st.tb_ctrl1};
      `PIS_OFF_STATUS: rdata = {26'h0000000, stack_full, st.vec_req, st.vec_id};
      default: rerr = 1'b1; // unmapped
    endcase
  end

  // hardware flag set events
  always_comb
  begin
    hw_set = '0;
    hw_set[`PIS_FB_CONV] = ev_conv_done;
    hw_set[`PIS_FB_SYNC] = ev_sync_byte | ev_sync_addr_match | ev_sync_timeout;
    hw_set[`PIS_FB_SEC] = ev_second_serial;
    hw_set[`PIS_FB_ASY0] = ~st.async_req_n[0];
    hw_set[`PIS_FB_ASY1] = ~st.async_req_n[1];
    hw_set[`PIS_FB_OV] = ev_overvolt;
    hw_set[`PIS_FB_TB0] = tb_ovf[0];
    hw_set[`PIS_FB_TB1] = tb_ovf[1];
    hw_set[`PIS_FB_MEM] = ev_mem_write_done;
    hw_set[`PIS_FB_LV] = ev_low_volt;
    hw_set[`PIS_FB_TM +: NUM_TM] = tm_req;
    // group flags follow enabled member events
    hw_set[`PIS_FB_MF0] = |(tm_req[1:0] & st.enables[`PIS_FB_TM +: 2]);
    hw_set[`PIS_FB_MF1] = |(tm_req[3:2] & st.enables[`PIS_FB_TM + 2 +: 2]);
    hw_set[`PIS_FB_MF2] = (ev_mem_write_done & st.enables[`PIS_FB_MEM])
                        | (ev_low_volt & st.enables[`PIS_FB_LV]);
  end

  // enabled pending sources and fixed priority pick
  always_comb
  begin
    pend = st.flags[`PIS_NUM_VEC-1:0] & st.enables[`PIS_NUM_VEC-1:0];
    pri_id = 4'h0;
    for (int i = `PIS_NUM_VEC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        pri_id = 4'(i); // lowest index wins
      end
    end
  end

  // software set and clear of flags
  always_comb
  begin
    sw_set = '0;
    clr = '0;
    if (wr && addr == `PIS_OFF_FLAG)
    begin
      clr = pwdata[`PIS_FLAG_W-1:0] & wmask[`PIS_FLAG_W-1:0]; // write one to clear
    end
    if (wr && addr == `PIS_OFF_FLAG_SET)
    begin
      sw_set = pwdata[`PIS_FLAG_W-1:0] & wmask[`PIS_FLAG_W-1:0]; // write one to set
    end
    if (st.vec_req && core_ack)
    begin
      // only the serviced vector flag; group members stay set
      clr[st.vec_id] = 1'b1;
    end
  end

  // next state
  always_comb
  begin
    nxt_st = st;
    // flags: set wins over clear
    nxt_st.flags = ((st.flags & ~clr) | hw_set | sw_set) & `PIS_FLAG_MASK;
    // wake on any hardware-set flag rising, enables ignored
    nxt_st.wake = |(hw_set & ~st.flags & `PIS_FLAG_MASK);
    // async low request pulse on rise of the OR of the channel's conditions
    nxt_st.async_prev = async_any;
    nxt_st.async_req_n = ~(async_any & ~st.async_prev);
    // apb ready one cycle into access, then drop
    nxt_st.pready = acc & ~st.pready;
    if (acc && !st.pready)
    begin
      nxt_st.prdata = pwrite ? 32'h00000000 : rdata;
      nxt_st.pslverr = rerr;
    end
    else
    begin
      nxt_st.pslverr = 1'b0;
    end
    // register writes
    if (wr && addr == `PIS_OFF_ENABLE)
    begin
      nxt_st.enables = ((st.enables & ~wmask[`PIS_FLAG_W-1:0])
                     | (pwdata[`PIS_FLAG_W-1:0] & wmask[`PIS_FLAG_W-1:0])) & `PIS_FLAG_MASK;
    end
    if (wr && addr == `PIS_OFF_PSC && pstrb[0])
    begin
      nxt_st.psc_sel = pwdata[1:0];
    end
    if (wr && addr == `PIS_OFF_TB0 && pstrb[0])
    begin
      nxt_st.tb_ctrl0 = pwdata[7:0] & `PIS_TB_MASK;
    end
    if (wr && addr == `PIS_OFF_TB1 && pstrb[0])
    begin
      nxt_st.tb_ctrl1 = pwdata[7:0] & `PIS_TB_MASK;
    end
    // global enable: service clears, reti sets, software writes
    if (st.vec_req && core_ack)
    begin
      nxt_st.gie = 1'b0;
    end
    else if (core_reti)
    begin
      nxt_st.gie = 1'b1; // plain return has no effect
    end
    else if (wr && addr == `PIS_OFF_CTRL && pstrb[0])
    begin
      nxt_st.gie = pwdata[`PIS_CTRL_GIE];
    end
    // vector request, held off while stack is full
    if (st.vec_req && core_ack)
    begin
      nxt_st.vec_req = 1'b0;
    end
    else
    begin
      nxt_st.vec_req = st.gie & (|pend) & ~stack_full;
      nxt_st.vec_id = pri_id;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.flags <= `PIS_RST_FLAGS;
      st.enables <= `PIS_RST_ENABLES;
      st.tb_ctrl0 <= `PIS_RST_TB;
      st.tb_ctrl1 <= `PIS_RST_TB;
      st.psc_sel <= `PIS_RST_PSC;
      st.async_req_n <= 2'h3;
    end
    else
    begin
      st <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign vec_req = st.vec_req;
  assign vec_id = st.vec_id;
  assign wake = st.wake;

endmodule

// >>> shared/pis_consts.svh
// Purpose: offsets, field positions, reset values and counts of the interrupt sources block
// Assumes: included by bare name by the package and by every design file
// Notes: definitions only
`ifndef PIS_CONSTS_SVH
`define PIS_CONSTS_SVH

// register byte offsets
`define PIS_OFF_CTRL 8'h00
`define PIS_OFF_ENABLE 8'h04
`define PIS_OFF_FLAG 8'h08
`define PIS_OFF_FLAG_SET 8'h0c
`define PIS_OFF_PSC 8'h10
`define PIS_OFF_TB0 8'h14
`define PIS_OFF_TB1 8'h18
`define PIS_OFF_STATUS 8'h1c

// flag and enable vector layout (same bit in both registers)
`define PIS_FLAG_W 20
`define PIS_FB_CONV 0
`define PIS_FB_SYNC 1
`define PIS_FB_SEC 2
`define PIS_FB_ASY0 3
`define PIS_FB_ASY1 4
`define PIS_FB_OV 5
`define PIS_FB_TB0 6
`define PIS_FB_TB1 7
`define PIS_FB_MF0 8
`define PIS_FB_MF1 9
`define PIS_FB_MF2 10
`define PIS_FB_MEM 11
`define PIS_FB_LV 12
`define PIS_FB_TM 16
`define PIS_NUM_VEC 11
`define PIS_FLAG_MASK 20'hf1fff

// control register fields
`define PIS_CTRL_GIE 0
`define PIS_TB_ON 7
`define PIS_TB_PER_W 3
`define PIS_TB_MASK 8'h87
`define PIS_PSC_MASK 8'h03

// prescaler source codes and time base exponent
`define PIS_PSC_SYS 2'h0
`define PIS_PSC_SYS4 2'h1
`define PIS_TB_BASE_EXP 5'h08

// reset values
`define PIS_RST_FLAGS 20'h00000
`define PIS_RST_ENABLES 20'h00000
`define PIS_RST_TB 8'h00
`define PIS_RST_PSC 2'h0

`endif

// >>> shared/pis_pkg.sv
// Purpose: state types of the interrupt sources block
// Assumes: constants come from the guarded header
// Notes: one packed struct per module holds all its state
`include "pis_consts.svh"
package pis_pkg;

  // top level state
  typedef struct packed {
    logic gie;                            // global enable
    logic [`PIS_FLAG_W-1:0] flags;        // request flags
    logic [`PIS_FLAG_W-1:0] enables;      // per source enables
    logic [1:0] psc_sel;                  // prescaler source
    logic [7:0] tb_ctrl0;                 // time base 0 control
    logic [7:0] tb_ctrl1;                 // time base 1 control
    logic [1:0] async_prev;               // async condition history
    logic [1:0] async_req_n;              // async low request pulse
    logic [31:0] prdata;                  // apb read data
    logic pready;                         // apb ready
    logic pslverr;                        // apb error
    logic vec_req;                        // vector request to core
    logic [3:0] vec_id;                   // vector number
    logic wake;                           // wake pulse
  } pis_state_t;

  // prescaler state
  typedef struct packed {
    logic [1:0] div;                      // divide by four count
    logic tick;                           // prescaler clock enable
  } pis_psc_state_t;

  // time base state
  typedef struct packed {
    logic [15:0] cnt;                     // prescaler tick count
    logic ovf;                            // overflow pulse
  } pis_tb_state_t;

endpackage

// >>> rtl/pis_prescaler.sv
// Purpose: time base prescaler clock enable from a selectable source
// Assumes: sub_tick is a one-cycle enable of the low speed sub clock
// Notes: output is a one-cycle enable pulse on pclk
`timescale 1ns/1ns
`include "pis_consts.svh"
module pis_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] sel,
  input wire logic sub_tick,
  output logic psc_tick
);

  pis_pkg::pis_psc_state_t st; // registered state
  pis_pkg::pis_psc_state_t nxt_st; // next state

  // source select
  always_comb
  begin
    nxt_st = st;
    nxt_st.div = st.div + 2'h1;
    if (sel == `PIS_PSC_SYS)
    begin
      nxt_st.tick = 1'b1; // every system clock
    end
    else if (sel == `PIS_PSC_SYS4)
    begin
      nxt_st.tick = (st.div == 2'h3); // one in four
    end
    else
    begin
      nxt_st.tick = sub_tick; // sub clock
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= nxt_st;
    end
  end

  assign psc_tick = st.tick;

endmodule

// >>> rtl/pis_timebase.sv
// Purpose: one time base divider with on bit and period select
// Assumes: psc_tick is a one-cycle prescaler enable
// Notes: period is 2^(8+code) prescaler ticks; off holds the count at zero
`timescale 1ns/1ns
`include "pis_consts.svh"
module pis_timebase (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tb_on,
  input wire logic [`PIS_TB_PER_W-1:0] period,
  input wire logic psc_tick,
  output logic tb_ovf
);

  pis_pkg::pis_tb_state_t st; // registered state
  pis_pkg::pis_tb_state_t nxt_st; // next state
  logic [4:0] exp_sel; // time-out exponent
  logic [15:0] term; // last count before overflow

  // divider and overflow pulse
  always_comb
  begin
    exp_sel = `PIS_TB_BASE_EXP + {2'h0, period};
    term = (16'h0001 << exp_sel[3:0]) - 16'h0001;
    nxt_st = st;
    nxt_st.ovf = 1'b0;
    if (!tb_on)
    begin
      nxt_st.cnt = 16'h0000; // stopped
    end
    else if (psc_tick)
    begin
      if (st.cnt >= term)
      begin
        nxt_st.cnt = 16'h0000;
        nxt_st.ovf = 1'b1; // time-out reached
      end
      else
      begin
        nxt_st.cnt = st.cnt + 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= nxt_st;
    end
  end

  assign tb_ovf = st.ovf;

endmodule

// >>> tb/pis_props.sv
// Purpose: port level checks of the interrupt sources block
// Assumes: one clock domain, asynchronous active low reset
// Notes: bound into pis_top, watches its ports only
`timescale 1ns/1ns
`include "pis_consts.svh"
module pis_props #(
  parameter int ADDR_W = 8,
  parameter int NUM_TM = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ev_mem_write_done,
  input wire logic ev_conv_done,
  input wire logic ev_sync_byte,
  input wire logic ev_sync_addr_match,
  input wire logic ev_sync_timeout,
  input wire logic ev_second_serial,
  input wire logic [5:0] async0_cond,
  input wire logic [5:0] async1_cond,
  input wire logic ev_overvolt,
  input wire logic ev_low_volt,
  input wire logic [NUM_TM-1:0] tm_req,
  input wire logic stack_full,
  input wire logic core_ack,
  input wire logic vec_req,
  input wire logic [3:0] vec_id,
  input wire logic wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ev_any; // any single cycle hardware event
  assign ev_any = ev_mem_write_done | ev_conv_done | ev_sync_byte | ev_sync_addr_match | ev_sync_timeout
    | ev_second_serial | ev_overvolt | ev_low_volt | (|tm_req);
  logic [1:0] tb_on_ff; // on bits of both time bases as last written
  // mirror the time base on bits, a running time base is a wake cause too
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tb_on_ff <= 2'h0;
    end
    else if (psel && penable && pready && pwrite && pstrb[0] && paddr == `PIS_OFF_TB0)
    begin
      tb_on_ff[0] <= pwdata[`PIS_TB_ON];
    end
    else if (psel && penable && pready && pwrite && pstrb[0] && paddr == `PIS_OFF_TB1)
    begin
      tb_on_ff[1] <= pwdata[`PIS_TB_ON];
    end
  end
  // one wait state, one cycle answer
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read nonzero");
  stack_block_a: assert property (stack_full |=> !vec_req) else $error("vector while stack full");
  ack_drop_a: assert property (vec_req && core_ack |=> !vec_req) else $error("vector after ack");
  wake_cause_a: assert property (wake |-> $past(ev_any) || $past(|{async0_cond, async1_cond}, 2)
    || $past(|tb_on_ff, 2)) else $error("wake without event");
  vec_range_a: assert property (vec_req |-> vec_id < `PIS_NUM_VEC) else $error("vector out of range");
  status_read_a: assert property (pready && !pwrite && paddr == `PIS_OFF_STATUS |->
    prdata == {26'h0, $past(stack_full), $past(vec_req), $past(vec_id)}) else $error("status mismatch");
  psc_width_a: assert property (pready && !pwrite && paddr == `PIS_OFF_PSC |-> prdata[31:2] == 30'h0)
    else $error("prescaler select too wide");
endmodule
bind pis_top pis_props #(.ADDR_W(ADDR_W), .NUM_TM(NUM_TM)) u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ev_mem_write_done, .ev_conv_done, .ev_sync_byte,
  .ev_sync_addr_match,
  .ev_sync_timeout, .ev_second_serial, .async0_cond, .async1_cond, .ev_overvolt, .ev_low_volt, .tm_req,
  .stack_full, .core_ack, .vec_req, .vec_id, .wake);

// >>> tb/pis_core_model.sv
// Purpose: processor core side that takes vectors
// Assumes: vec_req is a held level until acknowledged
// Notes: ack after dly cycles, optional return with global re-enable
`timescale 1ns/1ns
module pis_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic vec_req,
  input wire logic use_reti,
  input wire logic [3:0] dly,
  output logic core_ack,
  output logic core_reti
);
  int cnt; // cycles a vector has been shown
  logic [2:0] sh; // ack history, return follows four cycles later
  // take one vector at a time, then return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      sh <= 3'h0;
      core_ack <= 1'b0;
      core_reti <= 1'b0;
    end
    else
    begin
      sh <= {sh[1:0], core_ack};
      core_reti <= use_reti && sh[2];
      core_ack <= vec_req && !core_ack && cnt >= dly;
      cnt <= (vec_req && !core_ack && cnt < dly) ? cnt + 1 : 0;
    end
  end
endmodule

// >>> tb/test_pis_top.sv
// Purpose: self checking bench of the interrupt sources block
// Assumes: apb master tasks, core model acks vectors
// Notes: event index k maps onto the packed ev vector
`timescale 1ns/1ns
`include "pis_consts.svh"
module test_pis_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic stack_full = 1'b0, sub_tick = 1'b0, use_reti = 1'b0;
  logic [3:0] dly = 4'h1;
  logic [1:0] sc = 2'h0; // sub clock divider, period three
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [23:0] ev = 24'h0; // all event inputs
  logic [3:0] vec_id;
  logic pready, pslverr, err, vec_req, wake, core_ack, core_reti;
  int fail_count = 0;
  int n_compared = 0;
  int wn, t;
  int wk = 0; // wake pulses seen
  pis_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev_conv_done(ev[0]),
    .ev_sync_byte(ev[1]), .ev_sync_addr_match(ev[2]), .ev_sync_timeout(ev[3]), .ev_second_serial(ev[4]),
    .ev_overvolt(ev[5]), .async0_cond(ev[11:6]), .async1_cond(ev[17:12]), .ev_mem_write_done(ev[18]),
    .ev_low_volt(ev[19]), .tm_req(ev[23:20]), .sub_tick(sub_tick), .stack_full(stack_full),
    .core_ack(core_ack), .core_reti(core_reti), .vec_req(vec_req), .vec_id(vec_id), .wake(wake));
  pis_core_model core (.pclk(pclk), .presetn(presetn), .vec_req(vec_req), .use_reti(use_reti), .dly(dly),
    .core_ack(core_ack), .core_reti(core_reti));
  // clock and slow sub clock enable
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    sc <= (sc == 2'h2) ? 2'h0 : sc + 2'h1;
    sub_tick <= sc == 2'h2;
  end
  // count wake pulses where they are settled
  always @(negedge pclk)
  begin
    if (wake === 1'b1) wk <= wk + 1;
  end
  task report_and_stop;
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1); // only the watchdog ends a hang
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task fire(input int k);
    @(posedge pclk);
    ev <= 24'h1 << k;
    @(posedge pclk);
    ev <= 24'h0;
  endtask
  // wait for vec_req level, counting falling edges
  task wv(input logic l);
    wn = 0;
    do @(negedge pclk); while (vec_req !== l && ++wn < 2000);
    wn++;
    if (wn > 2000) chk(32'h0, 32'h1);
  endtask
  function automatic logic [31:0] vx(input int k);
    if (k == 0) return 0;
    if (k < 4) return 1;
    if (k == 4) return 2;
    if (k == 5) return 5;
    if (k < 12) return 3;
    if (k < 18) return 4;
    if (k < 20) return 10;
    return k < 22 ? 8 : 9;
  endfunction
  function automatic logic [31:0] mb(input int k);
    if (k == 18) return 32'h800;
    if (k == 19) return 32'h1000;
    return k > 19 ? 32'h1 << (k - 4) : 32'h0;
  endfunction
  // time base period between two vectors
  task tbm(input logic [31:0] ps, input logic [7:0] r, input logic [31:0] c, input int e);
    apb(1'b1, `PIS_OFF_PSC, ps);
    apb(1'b1, r, c);
    wv(1'b1);
    wv(1'b0);
    t = wn;
    wv(1'b1);
    chk(t + wn, e);
    apb(1'b1, r, 32'h0);
    repeat (20) @(negedge pclk);
  endtask
  initial
  begin
    #300000; // about five times the expected run
    fail_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rdc(8'(a), 32'h0);
    apb(1'b1, 8'h20, 32'h1);
    chk(err, 1'b1);
    apb(1'b1, `PIS_OFF_PSC, 32'hffffffff);
    rdc(`PIS_OFF_PSC, 32'h3);
    apb(1'b1, `PIS_OFF_TB0, 32'hffffffff);
    rdc(`PIS_OFF_TB0, 32'h87);
    apb(1'b1, `PIS_OFF_TB0, 32'h0);
    apb(1'b1, `PIS_OFF_ENABLE, `PIS_FLAG_MASK);
    // every source, plain return each time
    for (int k = 0; k < 24; k++)
    begin
      dly <= 4'(k % 4);
      apb(1'b1, `PIS_OFF_CTRL, 32'h1);
      fire(k);
      wv(1'b1);
      chk(vec_id, vx(k));
      wv(1'b0);
      rdc(`PIS_OFF_FLAG, mb(k));
      rdc(`PIS_OFF_CTRL, 32'h0);
      apb(1'b1, `PIS_OFF_FLAG, mb(k));
    end
    chk(wk, 24);
    // software set shows in the flags but gives no wake
    apb(1'b1, `PIS_OFF_FLAG_SET, 32'h1000);
    rdc(`PIS_OFF_FLAG_SET, 32'h1000);
    chk(wk, 24);
    apb(1'b1, `PIS_OFF_FLAG, 32'h1000);
    // group enable off holds the write-done vector back
    apb(1'b1, `PIS_OFF_ENABLE, 32'hf1bff);
    apb(1'b1, `PIS_OFF_CTRL, 32'h1);
    fire(18);
    repeat (20) @(negedge pclk);
    chk(vec_req, 1'b0);
    rdc(`PIS_OFF_FLAG, 32'hc00);
    chk(wk, 25);
    apb(1'b1, `PIS_OFF_ENABLE, `PIS_FLAG_MASK);
    wv(1'b1);
    chk(vec_id, 4'ha);
    wv(1'b0);
    apb(1'b1, `PIS_OFF_FLAG, 32'h800);
    // full stack keeps the request pending
    @(posedge pclk);
    stack_full <= 1'b1;
    apb(1'b1, `PIS_OFF_CTRL, 32'h1);
    fire(0);
    repeat (20) @(negedge pclk);
    chk(vec_req, 1'b0);
    @(posedge pclk);
    stack_full <= 1'b0;
    wv(1'b1);
    chk(vec_id, 4'h0);
    wv(1'b0);
    // two pending, served in order with return; the last ack's return slot passes first
    repeat (4) @(posedge pclk);
    use_reti <= 1'b1;
    fire(5);
    fire(0);
    apb(1'b1, `PIS_OFF_CTRL, 32'h1);
    wv(1'b1);
    chk(vec_id, 4'h0);
    wv(1'b0);
    wv(1'b1);
    chk(vec_id, 4'h5);
    wv(1'b0);
    repeat (8) @(negedge pclk);
    rdc(`PIS_OFF_CTRL, 32'h1);
    tbm(32'h0, `PIS_OFF_TB0, 32'h80, 256);
    tbm(32'h1, `PIS_OFF_TB0, 32'h80, 1024);
    tbm(32'h2, `PIS_OFF_TB0, 32'h80, 768);
    tbm(32'h0, `PIS_OFF_TB1, 32'h81, 512);
    report_and_stop;
  end
endmodule
